/* File: common/sscl_pkg.sv */
// Shared constants for the serial switch control latch.
// Assumes one 200 MHz system clock; all serial control pins arrive asynchronously.
package sscl_pkg;

   // ==========================================================
   // Widths
   localparam int SSCL_CHANNELS   = 32;   // Switches, shift stages, latch bits
   localparam int SSCL_FIFO_WIDTH = 1;    // One serial bit per entry
   localparam int SSCL_FIFO_DEPTH = 4;    // Bits buffered between edge and shift
   localparam int SSCL_SYNC_PINS  = 4;    // Shift clock, data, load, mode

   // ==========================================================
   // Pin positions inside the synchroniser vector
   localparam int SSCL_PIN_SCLK = 0;
   localparam int SSCL_PIN_DIN  = 1;
   localparam int SSCL_PIN_LOAD = 2;
   localparam int SSCL_PIN_MODE = 3;

   // ==========================================================
   // Values after reset
   localparam logic [31:0] SSCL_SHIFT_RST = 32'h0000_0000;
   localparam logic [31:0] SSCL_LATCH_RST = 32'h0000_0000;
   localparam logic [31:0] SSCL_SW_RST    = 32'h0000_0000;
   localparam logic [3:0]  SSCL_SYNC_RST  = 4'h4;  // Load line idles high

   // ==========================================================
   // Timing
   localparam int SSCL_CLK_PERIOD_PS   = 5000;   // 200 MHz system clock
   localparam int SSCL_SCLK_MAX_KHZ    = 60000;  // Fastest legal shift clock
   localparam int SSCL_SCLK_MIN_PER_PS = 1000000000 / SSCL_SCLK_MAX_KHZ;
   // Whole system cycles in the shortest shift clock period
   localparam int SSCL_SCLK_MIN_CYC    =
      SSCL_SCLK_MIN_PER_PS / SSCL_CLK_PERIOD_PS;

endpackage

/* File: common/sscl_fifo_if.sv */
// Push and pop channel between the edge detector and the shift stage.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface sscl_fifo_if #(parameter int WIDTH = 1);
   logic             push_valid;
   logic             push_ready;
   logic [WIDTH-1:0] push_data;
   logic             pop_valid;
   logic             pop_ready;
   logic [WIDTH-1:0] pop_data;

   // ==========================================================
   // Producer/consumer side and buffer side
   modport user (output push_valid, push_data, pop_ready,
                 input  push_ready, pop_valid, pop_data);
   modport buf_side (input  push_valid, push_data, pop_ready,
                     output push_ready, pop_valid, pop_data);
endinterface

/* File: design/sscl_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes synchronous active-high reset on the shared clock.
`timescale 1ns/1ps
module sscl_fifo
   import sscl_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
)(
   // Clock and reset
   input  wire logic  clk_in,
   input  wire logic  rst_in,
   // Buffer channel
   sscl_fifo_if.buf_side f
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, next_wr_ptr;
   logic [AW-1:0]    rd_ptr, next_rd_ptr;
   logic [AW:0]      count,  next_count;
   logic             do_push, do_pop;

   // ==========================================================
   // Handshake and pointer arithmetic
   always_comb begin
      do_push     = f.push_valid & f.push_ready;
      do_pop      = f.pop_valid & f.pop_ready;
      next_wr_ptr = do_push ? wr_ptr + AW'(1) : wr_ptr;
      next_rd_ptr = do_pop  ? rd_ptr + AW'(1) : rd_ptr;
      next_count  = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   // Honest full and empty
   assign f.push_ready = (count != (AW+1)'(DEPTH));
   assign f.pop_valid  = (count != '0);
   assign f.pop_data   = mem[rd_ptr];

   // Pointer registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage, written by index
   always_ff @(posedge clk_in) begin
      if (do_push) begin
         mem[wr_ptr] <= f.push_data;
      end
   end
endmodule

/* File: design/sscl_top.sv */
// Serial switch control latch: shift register, load latch, switch drive.
// Assumes shift clock, data, load and mode pins are asynchronous to
// ref_clk_in and the shift clock stays at or below 60 MHz.
`timescale 1ns/1ps
module sscl_top
   import sscl_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // Serial control pins
   input  wire logic        shift_clk_in,
   input  wire logic        ser_data_in,
   input  wire logic        latch_load_n_in,
   input  wire logic        mode_in,
   // Chain output
   output logic             ser_data_out,
   // Switch controls, one closes the switch
   output logic [31:0]      sw_on_out,
   // Buffer overrun, sticky until reset
   output logic             overrun_out
);

   // ==========================================================
   // Pin synchroniser
   logic [SSCL_SYNC_PINS-1:0] sync1, next_sync1;
   logic [SSCL_SYNC_PINS-1:0] sync2, next_sync2;
   logic                      sclk_prev, next_sclk_prev;

   // First stage read only by the second stage
   always_comb begin
      next_sync1 = {mode_in, latch_load_n_in, ser_data_in, shift_clk_in};
      next_sync2 = sync1;
      next_sclk_prev = sync2[SSCL_PIN_SCLK];
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sync1     <= SSCL_SYNC_RST;
         sync2     <= SSCL_SYNC_RST;
         sclk_prev <= 1'b0;
      end else begin
         sync1     <= next_sync1;
         sync2     <= next_sync2;
         sclk_prev <= next_sclk_prev;
      end
   end

   // ==========================================================
   // Edge capture into the buffer
   sscl_fifo_if #(.WIDTH(SSCL_FIFO_WIDTH)) fq ();
   logic sclk_rise;
   logic load_dly, next_load_dly;
   logic ovf, next_ovf;

   // Rising edge only, falling edge ignored
   assign sclk_rise     = sync2[SSCL_PIN_SCLK] & ~sclk_prev;
   assign fq.push_valid = sclk_rise;
   assign fq.push_data  = sync2[SSCL_PIN_DIN];
   assign fq.pop_ready  = 1'b1;  // Shift stage drains every cycle

   sscl_fifo #(
      .WIDTH (SSCL_FIFO_WIDTH),
      .DEPTH (SSCL_FIFO_DEPTH)
   ) u_fifo (
      .clk_in (ref_clk_in),
      .rst_in (rst_in),
      .f      (fq.buf_side)
   );

   // Overrun flag and load line aligned with the buffer latency
   always_comb begin
      next_ovf      = ovf | (sclk_rise & ~fq.push_ready);
      next_load_dly = sync2[SSCL_PIN_LOAD];
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ovf      <= 1'b0;
         load_dly <= 1'b1;
      end else begin
         ovf      <= next_ovf;
         load_dly <= next_load_dly;
      end
   end

   // ==========================================================
   // Shift register, latch and switch drive
   logic [31:0] shift_q, next_shift_q;
   logic [31:0] latch_q, next_latch_q;
   logic [31:0] sw_q,    next_sw_q;

   // Next values of the data path
   always_comb begin
      next_shift_q = shift_q;
      if (fq.pop_valid) begin
         next_shift_q = {shift_q[30:0], fq.pop_data[0]};
      end
      // Transparent while load line low, held while high
      next_latch_q = load_dly ? latch_q : shift_q;
      // Global control or per-bit latch drive
      if (sync2[SSCL_PIN_MODE]) begin
         next_sw_q = {32{sync2[SSCL_PIN_DIN]}};
      end else begin
         next_sw_q = latch_q;
      end
   end

   // Data path registers, cleared so all switches start open
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         shift_q <= SSCL_SHIFT_RST;
         latch_q <= SSCL_LATCH_RST;
         sw_q    <= SSCL_SW_RST;
      end else begin
         shift_q <= next_shift_q;
         latch_q <= next_latch_q;
         sw_q    <= next_sw_q;
      end
   end

   // ==========================================================
   // Outputs straight from flip-flops
   assign ser_data_out = shift_q[31];
   assign sw_on_out    = sw_q;
   assign overrun_out  = ovf;
endmodule

/* File: verif/sscl_top_asserts.sv */
// Checker on the switch latch top ports.
// Assumes one system clock and a synchronous high reset.
`timescale 1ns/1ps
module sscl_chk (
   // Watched ports
   input wire logic        ref_clk_in,
   input wire logic        rst_in,
   input wire logic        shift_clk_in,
   input wire logic        ser_data_in,
   input wire logic        latch_load_n_in,
   input wire logic        mode_in,
   input wire logic        ser_data_out,
   input wire logic [31:0] sw_on_out,
   input wire logic        overrun_out
);
   // =======
   // Port relations on the system clock
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   a_all_on: assert property (
      (mode_in && ser_data_in)[*4] |=> sw_on_out == 32'hFFFF_FFFF)
      else $error("switches not all on");
   a_all_off: assert property (
      (mode_in && !ser_data_in)[*4] |=> sw_on_out == 32'h0)
      else $error("switches not all off");
   a_mode_uniform: assert property (
      mode_in[*4] |=> sw_on_out == 32'h0 || sw_on_out == 32'hFFFF_FFFF)
      else $error("global mode not uniform");
   a_latch_hold: assert property (
      (!mode_in && latch_load_n_in)[*8] |=> $stable(sw_on_out))
      else $error("latch moved while held");
   a_load_bit31: assert property (
      (!mode_in && !latch_load_n_in && !shift_clk_in)[*8]
      |=> sw_on_out[31] == ser_data_out)
      else $error("switch 31 not last stage");
   a_shift_idle: assert property (
      (!shift_clk_in)[*8] |=> $stable(ser_data_out))
      else $error("shift without rising edge");
   a_dout_edge: assert property (
      $changed(ser_data_out)
      |-> $past(shift_clk_in, 3) || $past(shift_clk_in, 4))
      else $error("data out moved off edge");
   a_reset_clear: assert property (
      $fell(rst_in) |-> sw_on_out == 32'h0 && !ser_data_out)
      else $error("outputs not clear after reset");
endmodule
bind sscl_top sscl_chk u_chk (.ref_clk_in, .rst_in, .shift_clk_in,
   .ser_data_in, .latch_load_n_in, .mode_in, .ser_data_out,
   .sw_on_out, .overrun_out);

/* File: verif/sscl_ctl_model.sv */
// Controller model for the serial pins.
// Assumes pins change just after a system clock edge.
`timescale 1ns/1ps
module sscl_ctl_model (
   // Clock
   input  wire logic ref_clk_in,
   // Serial pins
   output logic      sclk_out,
   output logic      sdat_out,
   output logic      load_n_out
);
   // Idle levels
   initial begin
      sclk_out   = 1'b0;
      sdat_out   = 1'b0;
      load_n_out = 1'b1;
   end
   // One bit in 5 cycles, 40 MHz
   task automatic send_bit(input logic b);
      @(posedge ref_clk_in) sdat_out <= b;
      @(posedge ref_clk_in);
      @(posedge ref_clk_in) sclk_out <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      sclk_out <= 1'b0;
   endtask
   // Word, first bit ends at switch 31; data then flips
   task automatic send_word(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         send_bit(w[i]);
      end
      @(posedge ref_clk_in) sdat_out <= ~sdat_out;
   endtask
   // Data level for global mode
   task automatic set_data(input logic b);
      @(posedge ref_clk_in) sdat_out <= b;
   endtask
   // Load pulse after a settling gap
   task automatic pulse_load();
      repeat (3) @(posedge ref_clk_in);
      load_n_out <= 1'b0;
      repeat (10) @(posedge ref_clk_in);
      load_n_out <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
   endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the switch latch.
// Assumes the controller model owns the serial pins.
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk_in, rst_in, mode_in;
   logic        sclk, sdat, load_n, dout, ovr;
   logic [31:0] sw;
   int          error_cnt, total_checks;
   // Block and controller
   sscl_top uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .shift_clk_in(sclk), .ser_data_in(sdat),
      .latch_load_n_in(load_n), .mode_in(mode_in),
      .ser_data_out(dout), .sw_on_out(sw), .overrun_out(ovr));
   sscl_ctl_model ctl (.ref_clk_in(ref_clk_in), .sclk_out(sclk),
      .sdat_out(sdat), .load_n_out(load_n));
   // Clock
   initial begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Reset for 2 cycles, outputs clear
   task automatic t_reset();
      @(posedge ref_clk_in) rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      #1;
      chk({30'h0, dout, ovr}, 32'h0);
      chk(sw, 32'h0);
   endtask
   // Shift a word, load it
   task automatic t_load(input logic [31:0] w);
      ctl.send_word(w);
      ctl.pulse_load();
      #1;
      chk(sw, w);
      chk({31'h0, dout}, {31'h0, w[31]});
      chk({31'h0, ovr}, 32'h0);
   endtask
   // Shift with load high, one extra bit, then load
   task automatic t_hold(input logic [31:0] w, input logic [31:0] b);
      ctl.send_word(b);
      repeat (8) @(posedge ref_clk_in);
      #1;
      chk(sw, w);
      chk({31'h0, dout}, {31'h0, b[31]});
      ctl.send_bit(1'b1);
      repeat (8) @(posedge ref_clk_in);
      #1;
      chk({31'h0, dout}, {31'h0, b[30]});
      ctl.pulse_load();
      #1;
      chk(sw, {b[30:0], 1'b1});
   endtask
   // Global mode on, off, then back to latch
   task automatic t_mode(input logic [31:0] w);
      @(posedge ref_clk_in) mode_in <= 1'b1;
      ctl.set_data(1'b1);
      repeat (6) @(posedge ref_clk_in);
      #1;
      chk(sw, 32'hFFFF_FFFF);
      ctl.set_data(1'b0);
      repeat (6) @(posedge ref_clk_in);
      #1;
      chk(sw, 32'h0);
      @(posedge ref_clk_in) mode_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      #1;
      chk(sw, w);
   endtask
   // Main sequence
   initial begin
      rst_in = 1'b1;
      mode_in = 1'b0;
      error_cnt = 0;
      total_checks = 0;
      t_reset();
      t_load(32'hA5C3_0F96);
      t_hold(32'hA5C3_0F96, 32'h3C5A_96E1);
      t_mode(32'h78B5_2DC3);
      t_reset();
      wrap_up();
   end
   // Watchdog
   initial begin
      repeat (4000) @(posedge ref_clk_in);
      error_cnt++;
      wrap_up();
   end
endmodule
